/* File: bench/pct_peer_model.sv */
// Far-side model: quadrature encoder and peer timer trigger source
`timescale 1ns/10ps
module pct_peer_model
(
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_step,
   input  wire logic       i_dir,
   input  wire logic       i_fire,
   output logic      [1:0] o_ab,
   output logic            o_trig
);
   logic [1:0] phase;

   // ***************************************************
   // Encoder phase walk, one edge per step
   // ***************************************************
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         phase <= 2'h0;
      else if (i_step)
         phase <= i_dir ? phase + 2'h1 : phase - 2'h1;
   end

   // Gray order so only one line moves per step
   assign o_ab = {phase[1], phase[1] ^ phase[0]};

   // Peer trigger, low outside requested pulses
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_trig <= 1'b0;
      else
         o_trig <= i_fire;
   end
endmodule

/* File: bench/pct_timer_props.sv */
// Port-level checker for the PWM and capture timer
`timescale 1ns/10ps
module pct_timer_props
#(
   parameter int CNT_W   = 16,
   parameter int NCH     = 4,
   parameter bit UP_ONLY = 1'b0,
   parameter bit HAS_CMP = 1'b1
)
(
   input wire logic           i_clk,
   input wire logic           i_resetn,
   input wire logic [7:0]     i_addr,
   input wire logic [31:0]    i_wdata,
   input wire logic           i_wr,
   input wire logic           i_rd,
   input wire logic [31:0]    o_rdata,
   input wire logic [NCH-1:0] i_ch_in,
   input wire logic [NCH-1:0] o_ch_out,
   input wire logic [NCH-1:0] o_ch_outn,
   input wire logic           i_dbg_halt,
   input wire logic           i_trig_in,
   input wire logic           o_trig_out,
   input wire logic [NCH:0]   o_dma_req,
   input wire logic           o_irq
);
   import pct_pkg::*;
   pct_ctrl_t    ctrl_q;
   logic [NCH:0] mask_q;

   // ***************************************************
   // Shadow of software settings seen on the bus
   // ***************************************************
   // Hardware clearing of enable is not mirrored, so enable is never used
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ctrl_q <= pct_ctrl_t'(CTRL_RST);
      else if (i_wr && i_addr == OFS_CTRL)
         ctrl_q <= pct_ctrl_t'(i_wdata[7:0]);
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         mask_q <= '0;
      else if (i_wr && i_addr == OFS_MASK)
         mask_q <= i_wdata[NCH:0];
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // ***************************************************
   // Properties
   // ***************************************************
   rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data not zero outside read answer");
   unmapped_rd_a: assert property ((i_rd && i_addr >= 8'(OFS_CCR0 + CCR_STEP * NCH)) |=> o_rdata == '0)
      else $error("unmapped read not zero");
   trig_pulse_a: assert property (o_trig_out |=> !o_trig_out)
      else $error("update trigger longer than one cycle");
   dma_upd_a: assert property (o_dma_req[0] |-> o_trig_out)
      else $error("update request without update event");
   comp_excl_a: assert property ((o_ch_out & o_ch_outn) == '0)
      else $error("main and complementary both high");
   halt_off_a: assert property ((i_dbg_halt && ctrl_q.outoff_dbg)[*4] |-> (o_ch_out | o_ch_outn) == '0)
      else $error("outputs active while halted");
   halt_frz_a: assert property ((i_dbg_halt && ctrl_q.freeze_dbg)[*3] |-> !o_trig_out)
      else $error("update while counter frozen");
   irq_mask_a: assert property (mask_q == '0 |-> !o_irq)
      else $error("interrupt with all sources masked");
   peer_trig_a: assert property ((ctrl_q.slave_reset && $rose(i_trig_in)) |-> ##[1:3] o_trig_out)
      else $error("peer trigger gave no update");

   cover property (o_trig_out && o_dma_req[0]);
   cover property ($rose(o_irq));
   cover property (ctrl_q.opm && o_trig_out);
   cover property ($rose(o_ch_outn[0]));
endmodule

bind pct_timer pct_timer_props #(.CNT_W(CNT_W), .NCH(NCH), .UP_ONLY(UP_ONLY), .HAS_CMP(HAS_CMP)) u_props
(
   .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_ch_in(i_ch_in), .o_ch_out(o_ch_out), .o_ch_outn(o_ch_outn), .i_dbg_halt(i_dbg_halt),
   .i_trig_in(i_trig_in), .o_trig_out(o_trig_out), .o_dma_req(o_dma_req), .o_irq(o_irq)
);

/* File: bench/tb_top.sv */
// Self-checking bench for the PWM and capture timer
`timescale 1ns/10ps
module tb_top;
   import pct_pkg::*;
   logic        i_clk, i_resetn, i_wr, i_rd, i_dbg_halt, i_trig_in, o_trig_out, o_irq;
   logic        step_req, step_dir, fire;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, rv, w_rdata;
   logic [1:0]  ab, ch_hi;
   logic [3:0]  o_ch_out, o_ch_outn;
   logic [4:0]  o_dma_req;
   int          fails, check_count, n, psc, arr, cnt, k, bl, dl[3];

   pct_timer u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_ch_in({ch_hi, ab}), .o_ch_out(o_ch_out), .o_ch_outn(o_ch_outn),
      .i_dbg_halt(i_dbg_halt), .i_trig_in(i_trig_in), .o_trig_out(o_trig_out), .o_dma_req(o_dma_req), .o_irq(o_irq));
   pct_peer_model u_peer (.i_clk(i_clk), .i_resetn(i_resetn), .i_step(step_req), .i_dir(step_dir),
      .i_fire(fire), .o_ab(ab), .o_trig(i_trig_in));
   // Wide up-only one-channel build on the same bus
   pct_timer #(.CNT_W(32), .NCH(1), .UP_ONLY(1'b1)) u_dut_wide (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(w_rdata), .i_ch_in(ab[0]),
      .o_ch_out(), .o_ch_outn(), .i_dbg_halt(i_dbg_halt), .i_trig_in(i_trig_in), .o_trig_out(), .o_dma_req(),
      .o_irq());

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task tick;
      @(posedge i_clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a; i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // Cycles between two update pulses, bounded so a dead counter cannot hang
   task period(output int p);
      k = 0;
      while (o_trig_out !== 1'b1 && k < 4000) begin tick; k++; end
      p = 0;
      do begin tick; p++; end while (o_trig_out !== 1'b1 && p < 4000);
   endtask
   task step(input logic d);
      @(posedge i_clk);
      step_req <= 1'b1; step_dir <= d;
      @(posedge i_clk);
      step_req <= 1'b0;
      repeat (4) tick;
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // Longest path is under a thousand cycles; allow ample margin
   initial
   begin
      #(5 * 60000);
      fails++;
      close_out;
   end

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial
   begin
      i_resetn = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 32'h0; i_dbg_halt = 1'b0;
      step_req = 1'b0; step_dir = 1'b0; fire = 1'b0; ch_hi = 2'h0; fails = 0; check_count = 0;
      void'($urandom(32'h0AB7));
      repeat (5) @(posedge i_clk);
      i_resetn <= 1'b1;
      // Values after reset, unmapped place, prescaler top value
      rd(OFS_CTRL, rv);  check("ctrl", rv, 32'h0);
      rd(OFS_PSC, rv);   check("psc", rv, 32'h0);
      rd(OFS_ARR, rv);   check("arr", rv, 32'h0000FFFF);
      rd(OFS_DTIME, rv); check("dtime", rv, 32'h0);
      rd(8'h40, rv);     check("unmapped", rv, 32'h0);
      wr(OFS_PSC, 32'h0000FFFF);
      rd(OFS_PSC, rv);   check("psc max", rv, 32'h0000FFFF);
      // Update period in up, down and center modes
      wr(OFS_DMAEN, 32'h1);
      for (int m = 0; m < 3; m++)
      begin
         psc = $urandom % 4;
         arr = 2 + $urandom % 8;
         wr(OFS_CTRL, 32'h0); wr(OFS_PSC, 32'(psc)); wr(OFS_ARR, 32'(arr)); wr(OFS_CNT, 32'h0);
         wr(OFS_CTRL, 32'(m * 2 + 1));
         period(n);
         period(n);
         check("period", 32'(n), 32'((psc + 1) * ((m == 2) ? arr : arr + 1)));
      end
      // Sticky status, mask and read clear
      wr(OFS_CTRL, 32'h0);
      wr(OFS_MASK, 32'h0); tick; check("irq masked", 32'(o_irq), 32'h0);
      wr(OFS_MASK, 32'h1); tick; check("irq", 32'(o_irq), 32'h1);
      rd(OFS_STATUS, rv); check("status", rv & 32'h1, 32'h1);
      tick; check("irq clr", 32'(o_irq), 32'h0);
      rd(OFS_STATUS, rv); check("status clr", rv, 32'h0);
      // One period only in one-pulse mode
      wr(OFS_ARR, 32'h3); wr(OFS_PSC, 32'h0); wr(OFS_CNT, 32'h0); wr(OFS_CTRL, 32'h09);
      n = 0;
      repeat (60) begin tick; n += int'(o_trig_out === 1'b1); end
      check("opm pulses", 32'(n), 32'h1);
      rd(OFS_CTRL, rv); check("opm stop", rv & 32'h1, 32'h0);
      // PWM duty at both ends and inside
      wr(OFS_ARR, 32'h9); wr(OFS_CHCFG, 32'h3); wr(OFS_CTRL, 32'h11);
      dl = '{0, 1 + $urandom % 9, 10};
      foreach (dl[i])
      begin
         wr(OFS_CCR0, 32'(dl[i]));
         repeat (25) tick;
         n = 0;
         repeat (10) begin tick; n += int'(o_ch_out[0] === 1'b1); end
         check("duty", 32'(n), 32'(dl[i]));
      end
      // Dead band between main and complementary
      wr(OFS_DTIME, 32'h3); wr(OFS_CCR0, 32'h5);
      repeat (25) tick;
      bl = 0;
      repeat (10) begin tick; bl += int'(o_ch_out[0] === 1'b0 && o_ch_outn[0] === 1'b0); end
      check("dead band", 32'(bl >= 6), 32'h1);
      // Debug halt freezes count and switches outputs off
      wr(OFS_CTRL, 32'h71);
      @(posedge i_clk) i_dbg_halt <= 1'b1;
      repeat (6) tick;
      rd(OFS_CNT, rv);
      cnt = int'(rv);
      repeat (5) tick;
      rd(OFS_CNT, rv);
      check("frozen", rv, 32'(cnt));
      check("outs off", 32'(o_ch_out | o_ch_outn), 32'h0);
      @(posedge i_clk) i_dbg_halt <= 1'b0;
      // Peer trigger restarts and enables a stopped counter
      wr(OFS_CTRL, 32'h80);
      @(posedge i_clk) fire <= 1'b1;
      @(posedge i_clk) fire <= 1'b0;
      n = 0;
      repeat (5) begin tick; n += int'(o_trig_out === 1'b1); end
      check("peer update", 32'(n), 32'h1);
      rd(OFS_CTRL, rv); check("peer enable", rv & 32'h1, 32'h1);
      // Encoder steps forward and back, then a capture of the held count
      wr(OFS_CTRL, 32'h0); wr(OFS_ARR, 32'h0000FFFF); wr(OFS_CNT, 32'd100); wr(OFS_CHCFG, 32'h100);
      wr(OFS_CTRL, 32'h07);
      cnt = 100;
      n = 1 + $urandom % 20;
      repeat (n) begin step(1'b1); cnt++; end
      n = 1 + $urandom % 20;
      repeat (n) begin step(1'b0); cnt--; end
      rd(OFS_CNT, rv); check("encoder", rv, 32'(cnt));
      @(posedge i_clk) ch_hi <= 2'b01;
      repeat (6) tick;
      rd(OFS_CCR0 + 8'h08, rv); check("capture", rv, 32'(cnt));
      // Wide build keeps all 32 bits and ignores a down request
      wr(OFS_ARR, 32'h12345678); rd(OFS_ARR, rv);
      check("wide arr", w_rdata, 32'h12345678);
      check("arr 16", rv, 32'h00005678);
      wr(OFS_CTRL, 32'h0); wr(OFS_CNT, 32'h5); wr(OFS_CTRL, 32'h3);
      rd(OFS_CNT, rv);
      check("up only", w_rdata, 32'h6);
      check("down", rv, 32'h4);
      close_out;
   end
endmodule

/* File: logic/pct_deadtime.sv */
// Dead-time inserter producing one main and one complementary output
`timescale 1ns/10ps
module pct_deadtime
#(
   parameter int DT_W     = 8,
   parameter bit HAS_COMP = 1'b1
)
(
   input  wire logic            i_clk,
   input  wire logic            i_resetn,
   input  wire logic            i_ref,
   input  wire logic            i_en,
   input  wire logic [DT_W-1:0] i_dt,
   output logic                 o_main,
   output logic                 o_comp
);

   logic            ref_d;
   logic [DT_W-1:0] dcnt;

   // ***************************************************
   // Gap timer
   // ***************************************************

   // Each reference edge reloads the gap; both sides stay low meanwhile
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ref_d <= 1'b0;
         dcnt  <= '0;
      end
      else if (i_ref != ref_d)
      begin
         ref_d <= i_ref;
         dcnt  <= i_dt;
      end
      else if (dcnt != '0)
      begin
         dcnt <= dcnt - 1'b1;
      end
   end

   // Outputs registered so a switch never sees a combinational glitch
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_main <= 1'b0;
         o_comp <= 1'b0;
      end
      else
      begin
         o_main <= i_en & ref_d & (dcnt == '0);
         o_comp <= HAS_COMP & i_en & ~ref_d & (dcnt == '0);
      end
   end

endmodule

/* File: logic/pct_pkg.sv */
// Shared constants and types of the PWM and capture timer
package pct_pkg;

   // ***************************************************
   // Register byte offsets
   // ***************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PSC    = 8'h04;
   localparam logic [7:0] OFS_ARR    = 8'h08;
   localparam logic [7:0] OFS_CNT    = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK   = 8'h14;
   localparam logic [7:0] OFS_DMAEN  = 8'h18;
   localparam logic [7:0] OFS_DTIME  = 8'h1C;
   localparam logic [7:0] OFS_CHCFG  = 8'h20;
   localparam logic [7:0] OFS_CCR0   = 8'h24;
   localparam int         CCR_STEP   = 4;

   // ***************************************************
   // Field layout and values after reset
   // ***************************************************
   localparam int          CTRL_W    = 8;
   localparam int          CHCFG_BPC = 4;   // Config bits per channel
   localparam int          CFG_POL   = 2;   // Polarity bit in a slice
   localparam int          DT_W      = 8;
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [31:0] PSC_RST   = 32'h00000000;
   localparam logic [31:0] ARR_RST   = 32'h0000FFFF;
   localparam logic [7:0]  DT_RST    = 8'h00;

   // ***************************************************
   // Modes and control word
   // ***************************************************
   typedef enum logic [1:0] {CM_UP, CM_DOWN, CM_CENTER, CM_ENC} pct_cmode_t;
   typedef enum logic [1:0] {CH_OFF, CH_CAPTURE, CH_TOGGLE, CH_PWM} pct_chmode_t;

   typedef struct packed {
      logic       slave_reset;  // Peer trigger restarts counter
      logic       outoff_dbg;   // Outputs off while halted
      logic       freeze_dbg;   // Counter frozen while halted
      logic       main_en;      // Master output enable
      logic       opm;          // One-pulse mode
      pct_cmode_t cmode;
      logic       enable;
   } pct_ctrl_t;

endpackage

/* File: logic/pct_timer.sv */
// Prescaled auto-reload timer with capture, compare and PWM channels
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module pct_timer
#(
   parameter int CNT_W   = 16,
   parameter int NCH     = 4,
   parameter bit UP_ONLY = 1'b0,
   parameter bit HAS_CMP = 1'b1
)
(
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic [7:0]       i_addr,
   input  wire logic [31:0]      i_wdata,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   output logic      [31:0]      o_rdata,
   input  wire logic [NCH-1:0]   i_ch_in,
   output logic      [NCH-1:0]   o_ch_out,
   output logic      [NCH-1:0]   o_ch_outn,
   input  wire logic             i_dbg_halt,
   input  wire logic             i_trig_in,
   output logic                  o_trig_out,
   output logic      [NCH:0]     o_dma_req,
   output logic                  o_irq
);
   import pct_pkg::*;

   // ***************************************************
   // Registers and state
   // ***************************************************
   pct_ctrl_t              ctrl;
   pct_cmode_t             mode;
   logic [CNT_W-1:0]       psc;
   logic [CNT_W-1:0]       arr;
   logic [CNT_W-1:0]       cnt;
   logic [CNT_W-1:0]       psc_cnt;
   logic [CNT_W-1:0]       ccr [NCH];
   logic [NCH:0]           status;
   logic [NCH:0]           mask;
   logic [NCH:0]           dmaen;
   logic [NCH:0]           events;
   logic [DT_W-1:0]        dtime;
   logic [CHCFG_BPC*NCH-1:0] chcfg;
   logic                   count_down;
   logic                   trig_d;
   logic [NCH-1:0]         in_s1;
   logic [NCH-1:0]         in_s2;
   logic [NCH-1:0]         in_s3;
   logic [NCH-1:0]         ch_evt;
   logic [NCH-1:0]         ch_ref;
   logic [31:0]            next_rdata;
   logic [CNT_W-1:0]       next_cnt;
   logic                   next_down;
   logic                   upd_evt;
   logic                   frozen;
   logic                   outs_off;
   logic                   run;
   logic                   tick;
   logic                   sync_reset;
   logic                   enc_step;
   logic                   enc_up;
   logic                   cnt_moved;

   // Channel slice decoders shared by every channel
   function automatic pct_chmode_t ch_mode(input logic [CHCFG_BPC*NCH-1:0] cfg,
                                           input int n);
      ch_mode = pct_chmode_t'(cfg[CHCFG_BPC*n +: 2]);
   endfunction

   function automatic logic ch_pol(input logic [CHCFG_BPC*NCH-1:0] cfg,
                                   input int n);
      ch_pol = cfg[CHCFG_BPC*n + CFG_POL];
   endfunction

   // ***************************************************
   // Register writes
   // ***************************************************

   // Control word; a write beats the hardware clear and set
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ctrl <= pct_ctrl_t'(CTRL_RST);
      end
      else if (i_wr && i_addr == OFS_CTRL)
      begin
         ctrl <= pct_ctrl_t'(i_wdata[CTRL_W-1:0]);
      end
      else if (upd_evt && ctrl.opm)
      begin
         ctrl.enable <= 1'b0;
      end
      else if (sync_reset)
      begin
         ctrl.enable <= 1'b1;
      end
   end

   // Plain configuration registers
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         psc   <= PSC_RST[CNT_W-1:0];
         arr   <= ARR_RST[CNT_W-1:0];
         mask  <= '0;
         dmaen <= '0;
         dtime <= DT_RST;
         chcfg <= '0;
      end
      else if (i_wr)
      begin
         if (i_addr == OFS_PSC)
            psc <= i_wdata[CNT_W-1:0];
         if (i_addr == OFS_ARR)
            arr <= i_wdata[CNT_W-1:0];
         if (i_addr == OFS_MASK)
            mask <= i_wdata[NCH:0];
         if (i_addr == OFS_DMAEN)
            dmaen <= i_wdata[NCH:0];
         if (i_addr == OFS_DTIME)
            dtime <= i_wdata[DT_W-1:0];
         if (i_addr == OFS_CHCFG)
            chcfg <= i_wdata[CHCFG_BPC*NCH-1:0];
      end
   end

   // ***************************************************
   // Debug, peer trigger and input sampling
   // ***************************************************

   // Reduced variants lose the direction choice entirely
   assign mode = UP_ONLY ? CM_UP : ctrl.cmode;
   assign frozen = i_dbg_halt & ctrl.freeze_dbg;
   assign outs_off = ~ctrl.main_en | (i_dbg_halt & ctrl.outoff_dbg);
   assign run = ctrl.enable & ~frozen;
   // Compare as at-or-above so a smaller factor written mid-count cannot strand the divider
   assign tick = run & (psc_cnt >= psc);
   assign sync_reset = ctrl.slave_reset & i_trig_in & ~trig_d;

   // Peer trigger is on our clock, so only an edge register
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         trig_d <= 1'b0;
      else
         trig_d <= i_trig_in;
   end

   // Pin inputs pass two flops; the third only serves edge detection
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         in_s1 <= '0;
         in_s2 <= '0;
         in_s3 <= '0;
      end
      else
      begin
         in_s1 <= i_ch_in;
         in_s2 <= in_s1;
         in_s3 <= in_s2;
      end
   end

   // Encoder phases A and B on inputs 0 and 1, four counts per cycle
   generate
      if (NCH >= 2)
      begin : g_enc
         assign enc_step = (in_s2[0] != in_s3[0]) | (in_s2[1] != in_s3[1]);
         assign enc_up = in_s2[0] ^ in_s3[1];
      end
      else
      begin : g_noenc
         assign enc_step = 1'b0;
         assign enc_up = 1'b0;
      end
   endgenerate

   // ***************************************************
   // Prescaler and counter
   // ***************************************************

   // Factor is psc plus one, so 0 gives undivided counting
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         psc_cnt <= '0;
      else if (sync_reset || tick)
         psc_cnt <= '0;
      else if (run)
         psc_cnt <= psc_cnt + 1'b1;
   end

   // Next count, direction and the update event
   always_comb
   begin
      next_cnt = cnt;
      next_down = count_down;
      upd_evt = 1'b0;
      if (sync_reset)
      begin
         next_cnt = '0;
         next_down = 1'b0;
         upd_evt = 1'b1;
      end
      else if (mode == CM_ENC)
      begin
         if (run && enc_step)
         begin
            next_down = ~enc_up;
            if (enc_up)
               next_cnt = (cnt == arr) ? '0 : cnt + 1'b1;
            else
               next_cnt = (cnt == '0) ? arr : cnt - 1'b1;
         end
      end
      else if (tick)
      begin
         unique case (mode)
            CM_UP:
            begin
               next_down = 1'b0;
               next_cnt = (cnt >= arr) ? '0 : cnt + 1'b1;
               upd_evt = (cnt >= arr);
            end
            CM_DOWN:
            begin
               next_down = 1'b1;
               next_cnt = (cnt == '0) ? arr : cnt - 1'b1;
               upd_evt = (cnt == '0);
            end
            CM_CENTER:
            begin
               // Turn at either end; each turn is an update
               if (!count_down && cnt >= arr)
               begin
                  next_down = 1'b1;
                  next_cnt = cnt - 1'b1;
                  upd_evt = 1'b1;
               end
               else if (count_down && cnt == '0)
               begin
                  next_down = 1'b0;
                  next_cnt = cnt + 1'b1;
                  upd_evt = 1'b1;
               end
               else
                  next_cnt = count_down ? cnt - 1'b1 : cnt + 1'b1;
            end
            CM_ENC:
               next_cnt = cnt;
         endcase
      end
   end

   assign cnt_moved = (next_cnt != cnt);

   // Counter register; a software write overrides counting
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt <= '0;
         count_down <= 1'b0;
      end
      else if (i_wr && i_addr == OFS_CNT)
      begin
         cnt <= i_wdata[CNT_W-1:0];
      end
      else
      begin
         cnt <= next_cnt;
         count_down <= next_down;
      end
   end

   // ***************************************************
   // Channels
   // ***************************************************
   generate
      for (genvar i = 0; i < NCH; i++)
      begin : g_ch
         localparam logic [7:0] CCR_ADDR = OFS_CCR0 + 8'(CCR_STEP * i);
         pct_chmode_t cm;
         logic        match;
         logic        cap;

         assign cm = ch_mode(chcfg, i);
         assign match = cnt_moved & (next_cnt == ccr[i]);
         assign cap = (cm == CH_CAPTURE) & in_s2[i] & ~in_s3[i];
         assign ch_evt[i] = cap | (match & (cm == CH_TOGGLE || cm == CH_PWM));

         // Capture wins over a software write in the same cycle
         always_ff @(posedge i_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               ccr[i] <= '0;
            else if (cap)
               ccr[i] <= cnt;
            else if (i_wr && i_addr == CCR_ADDR)
               ccr[i] <= i_wdata[CNT_W-1:0];
         end

         // Reference waveform; idle low once the counter is disabled
         always_ff @(posedge i_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               ch_ref[i] <= 1'b0;
            else if (!ctrl.enable)
               ch_ref[i] <= 1'b0;
            else if (cm == CH_PWM)
               ch_ref[i] <= (cnt < ccr[i]);
            else if (cm == CH_TOGGLE && match)
               ch_ref[i] <= ~ch_ref[i];
            else if (cm != CH_TOGGLE)
               ch_ref[i] <= 1'b0;
         end

         pct_deadtime
         #(
            .DT_W     (DT_W),
            .HAS_COMP (HAS_CMP)
         )
         u_dt
         (
            .i_clk    (i_clk),
            .i_resetn (i_resetn),
            .i_ref    (ch_ref[i] ^ ch_pol(chcfg, i)),
            .i_en     (~outs_off & (cm == CH_TOGGLE || cm == CH_PWM)),
            .i_dt     (dtime),
            .o_main   (o_ch_out[i]),
            .o_comp   (o_ch_outn[i])
         );
      end
   endgenerate

   // ***************************************************
   // Events, interrupt, DMA and triggers
   // ***************************************************
   assign events = {ch_evt, upd_evt};

   // Sticky flags; an event in the clearing read is kept
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         status <= '0;
      else if (i_rd && i_addr == OFS_STATUS)
         status <= events;
      else
         status <= status | events;
   end

   assign o_irq = |(status & mask);

   // One-cycle requests, one line per event of this timer
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_dma_req  <= '0;
         o_trig_out <= 1'b0;
      end
      else
      begin
         o_dma_req  <= events & dmaen;
         o_trig_out <= upd_evt;
      end
   end

   // ***************************************************
   // Register reads
   // ***************************************************

   // Unmapped addresses read as zero
   always_comb
   begin
      next_rdata = '0;
      unique case (i_addr)
         OFS_CTRL:   next_rdata = 32'(ctrl);
         OFS_PSC:    next_rdata = 32'(psc);
         OFS_ARR:    next_rdata = 32'(arr);
         OFS_CNT:    next_rdata = 32'(cnt);
         OFS_STATUS: next_rdata = 32'(status);
         OFS_MASK:   next_rdata = 32'(mask);
         OFS_DMAEN:  next_rdata = 32'(dmaen);
         OFS_DTIME:  next_rdata = 32'(dtime);
         OFS_CHCFG:  next_rdata = 32'(chcfg);
         default:
         begin
            for (int k = 0; k < NCH; k++)
               if (i_addr == OFS_CCR0 + 8'(CCR_STEP * k))
                  next_rdata = 32'(ccr[k]);
         end
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_rdata <= '0;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= '0;
   end

endmodule
